// [fsub_pkg.sv]
// Package of opcode fields, constants and operation enumeration for the fractional subtract unit
package fsub_pkg;
	// ----------------------------------------
	// Instruction fields
	// ----------------------------------------
	localparam int VARIANT_BIT = 10;
	localparam int MINOR_LSB = 3;
	localparam int MINOR_MSB = 9;
	localparam int MAJOR_LSB = 0;
	localparam int MAJOR_MSB = 2;
	localparam logic [2:0] MAJOR_POOL = 3'h5;
	// ----------------------------------------
	// Minor opcodes of each family
	// ----------------------------------------
	localparam logic [6:0] MINOR_PAIR_SUB = 7'h41;
	localparam logic [6:0] MINOR_WORD_SUB = 7'h68;
	localparam logic [6:0] MINOR_PAIR_HALVE = 7'h49;
	localparam logic [6:0] MINOR_WORD_HALVE = 7'h51;
	// ----------------------------------------
	// Status register field and clamp values
	// ----------------------------------------
	localparam int OUFLAG_BIT = 20;
	localparam logic [15:0] HALF_MAX = 16'h7fff;
	localparam logic [15:0] HALF_MIN = 16'h8000;
	localparam logic [31:0] WORD_MAX = 32'h7fffffff;
	localparam logic [31:0] WORD_MIN = 32'h80000000;
	localparam logic [31:0] STATUS_RESET = 32'h00000000;
	// ----------------------------------------
	// Decoded operations, one-hot
	// ----------------------------------------
	typedef enum logic [7:0] {
		OP_NONE = 8'h01,
		OP_PAIR_WRAP = 8'h02,
		OP_PAIR_CLAMP = 8'h04,
		OP_WORD_CLAMP = 8'h08,
		OP_PAIR_HALVE = 8'h10,
		OP_PAIR_HALVE_RND = 8'h20,
		OP_WORD_HALVE = 8'h40,
		OP_WORD_HALVE_RND = 8'h80
	} sub_op_e;
endpackage

// [fsub_dec_if.sv]
// Interface carrying the decoded operation from decoder to datapath
`timescale 1ns/10ps
interface fsub_dec_if;
	import fsub_pkg::*;
	sub_op_e op;
	logic trap_reserved;
	logic trap_disabled;
	modport decoder (output op, output trap_reserved, output trap_disabled);
	modport datapath (input op, input trap_reserved, input trap_disabled);
endinterface

// [fsub_decode.sv]
// Instruction decoder for the fractional subtract unit
`timescale 1ns/10ps
module fsub_decode (
	// Instruction
	input wire logic [31:0] instr,
	input wire logic instr_valid,
	// Resource enables
	input wire logic dsp_enabled,
	input wire logic dsp_rev2_enabled,
	// Decoded result
	fsub_dec_if.decoder dec
);
	import fsub_pkg::*;

	// ----------------------------------------
	// Field selection
	// ----------------------------------------
	wire logic [6:0] minor = instr[MINOR_MSB:MINOR_LSB];
	wire logic variant = instr[VARIANT_BIT];
	wire logic pool_hit = instr[MAJOR_MSB:MAJOR_LSB] == MAJOR_POOL;
	wire logic fam_pair = pool_hit && minor == MINOR_PAIR_SUB;
	wire logic fam_word = pool_hit && minor == MINOR_WORD_SUB;
	wire logic fam_phalve = pool_hit && minor == MINOR_PAIR_HALVE;
	wire logic fam_whalve = pool_hit && minor == MINOR_WORD_HALVE;
	wire logic known = fam_pair || fam_word || fam_phalve || fam_whalve;
	// Halving forms need the second revision; the pair and word subtract forms need only the base set
	wire logic needs_rev2 = fam_phalve || fam_whalve;
	wire logic allowed = needs_rev2 ? dsp_rev2_enabled : dsp_enabled;

	// Variant bit picks clamp or round, and is ignored by the word subtract family; minor picks family
	assign dec.op = !(instr_valid && known && allowed) ? OP_NONE :
		fam_pair ? (variant ? OP_PAIR_CLAMP : OP_PAIR_WRAP) :
		fam_word ? OP_WORD_CLAMP :
		fam_phalve ? (variant ? OP_PAIR_HALVE_RND : OP_PAIR_HALVE) :
		(variant ? OP_WORD_HALVE_RND : OP_WORD_HALVE);
	// Traps replace execution
	assign dec.trap_reserved = instr_valid && !known;
	assign dec.trap_disabled = instr_valid && known && !allowed;
endmodule

// [fractional_subtract_unit.sv]
// Fractional subtract datapath with sticky overflow status bit
`timescale 1ns/10ps
module fractional_subtract_unit (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Instruction and operands
	input wire logic [31:0] instr,
	input wire logic instr_valid,
	input wire logic [31:0] minuend_operand,
	input wire logic [31:0] subtrahend_operand,
	// Resource enables
	input wire logic dsp_enabled,
	input wire logic dsp_rev2_enabled,
	// Software write of the status register
	input wire logic status_wr,
	input wire logic [31:0] status_wdata,
	// Results
	output logic [31:0] result,
	output logic result_valid,
	output logic exc_reserved,
	output logic exc_dsp_disabled,
	output logic [31:0] accumulate_status_reg
);
	import fsub_pkg::*;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	fsub_dec_if dec ();
	fsub_decode u_decode (
		.instr(instr),
		.instr_valid(instr_valid),
		.dsp_enabled(dsp_enabled),
		.dsp_rev2_enabled(dsp_rev2_enabled),
		.dec(dec)
	);

	// 17-bit sign-extended lane difference
	function automatic logic [16:0] lane_diff(input logic [15:0] a, input logic [15:0] b);
		lane_diff = {a[15], a} - {b[15], b};
	endfunction

	// Clamp a lane, given its wide difference
	function automatic logic [15:0] lane_clamp(input logic [16:0] d);
		if (d[16] == d[15]) begin
			lane_clamp = d[15:0];
		end else if (!d[16]) begin
			lane_clamp = HALF_MAX;
		end else begin
			lane_clamp = HALF_MIN;
		end
	endfunction

	// ----------------------------------------
	// Arithmetic
	// ----------------------------------------
	wire logic [16:0] diff_hi = lane_diff(minuend_operand[31:16], subtrahend_operand[31:16]);
	wire logic [16:0] diff_lo = lane_diff(minuend_operand[15:0], subtrahend_operand[15:0]);
	wire logic ovf_hi = diff_hi[16] != diff_hi[15];
	wire logic ovf_lo = diff_lo[16] != diff_lo[15];
	wire logic [32:0] diff_w = {minuend_operand[31], minuend_operand}
		- {subtrahend_operand[31], subtrahend_operand};
	wire logic ovf_w = diff_w[32] != diff_w[31];
	wire logic rnd = dec.op == OP_PAIR_HALVE_RND || dec.op == OP_WORD_HALVE_RND;
	wire logic [16:0] half_hi = diff_hi + {16'h0000, rnd};
	wire logic [16:0] half_lo = diff_lo + {16'h0000, rnd};
	wire logic [32:0] half_w = diff_w + {32'h00000000, rnd};
	wire logic [31:0] pair_wrap = {diff_hi[15:0], diff_lo[15:0]};
	wire logic [31:0] pair_clamp = {lane_clamp(diff_hi), lane_clamp(diff_lo)};
	wire logic [31:0] word_clamp = !ovf_w ? diff_w[31:0] : (diff_w[32] ? WORD_MIN : WORD_MAX);
	wire logic [31:0] pair_half = {half_hi[16:1], half_lo[16:1]};
	wire logic [31:0] word_half = half_w[32:1];

	// Result selection
	logic [31:0] next_result;
	always_comb begin
		case (dec.op)
			OP_PAIR_WRAP: next_result = pair_wrap;
			OP_PAIR_CLAMP: next_result = pair_clamp;
			OP_WORD_CLAMP: next_result = word_clamp;
			OP_PAIR_HALVE, OP_PAIR_HALVE_RND: next_result = pair_half;
			OP_WORD_HALVE, OP_WORD_HALVE_RND: next_result = word_half;
			default: next_result = 32'h00000000;
		endcase
	end

	// Overflow events from flag-setting forms only
	wire logic pair_op = dec.op == OP_PAIR_WRAP || dec.op == OP_PAIR_CLAMP;
	wire logic ovf_event = (pair_op && (ovf_hi || ovf_lo))
		|| (dec.op == OP_WORD_CLAMP && ovf_w);
	wire logic executes = dec.op != OP_NONE;

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			result <= 32'h00000000;
			result_valid <= 1'b0;
			exc_reserved <= 1'b0;
			exc_dsp_disabled <= 1'b0;
		end else begin
			result <= executes ? next_result : result;
			result_valid <= executes;
			exc_reserved <= dec.trap_reserved;
			exc_dsp_disabled <= dec.trap_disabled;
		end
	end

	// Status register; a same-cycle overflow wins over a software write
	logic [31:0] next_status;
	always_comb begin
		next_status = status_wr ? status_wdata : accumulate_status_reg;
		next_status[OUFLAG_BIT] = next_status[OUFLAG_BIT] | ovf_event;
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			accumulate_status_reg <= STATUS_RESET;
		end else begin
			accumulate_status_reg <= next_status;
		end
	end

	// ----------------------------------------
	// Checks on lane results
	// ----------------------------------------
	a_pair_wrap_val: assert property (@(posedge clk_sys) disable iff (sys_rst)
		dec.op == OP_PAIR_WRAP |=> result == $past({minuend_operand[31:16] - subtrahend_operand[31:16],
		minuend_operand[15:0] - subtrahend_operand[15:0]}))
		else $error("wrapping pair result wrong");
	a_pair_clamp_pos: assert property (@(posedge clk_sys) disable iff (sys_rst)
		dec.op == OP_PAIR_CLAMP && ovf_hi && !diff_hi[16] |=> result[31:16] == HALF_MAX)
		else $error("upper lane not clamped to max");
	a_pair_clamp_neg: assert property (@(posedge clk_sys) disable iff (sys_rst)
		dec.op == OP_PAIR_CLAMP && ovf_lo && diff_lo[16] |=> result[15:0] == HALF_MIN)
		else $error("lower lane not clamped to min");
	a_pair_clamp_pass: assert property (@(posedge clk_sys) disable iff (sys_rst)
		dec.op == OP_PAIR_CLAMP && !ovf_hi && !ovf_lo |=> result == $past({minuend_operand[31:16]
		- subtrahend_operand[31:16], minuend_operand[15:0] - subtrahend_operand[15:0]}))
		else $error("unclamped pair lane changed");
	a_pair_halve_val: assert property (@(posedge clk_sys) disable iff (sys_rst)
		dec.op == OP_PAIR_HALVE |=> result == $past({diff_hi[16:1], diff_lo[16:1]}))
		else $error("halving pair result wrong");
	a_pair_halve_rnd: assert property (@(posedge clk_sys) disable iff (sys_rst)
		dec.op == OP_PAIR_HALVE_RND
		|=> result == $past({diff_hi[16:1] + diff_hi[0], diff_lo[16:1] + diff_lo[0]}))
		else $error("rounding halving pair result wrong");

	// ----------------------------------------
	// Checks on word results
	// ----------------------------------------
	a_word_clamp_neg: assert property (@(posedge clk_sys) disable iff (sys_rst)
		dec.op == OP_WORD_CLAMP && ovf_w && diff_w[32] |=> result == WORD_MIN)
		else $error("word not clamped to min");
	a_word_clamp_pos: assert property (@(posedge clk_sys) disable iff (sys_rst)
		dec.op == OP_WORD_CLAMP && ovf_w && !diff_w[32] |=> result == WORD_MAX)
		else $error("word not clamped to max");
	a_word_clamp_pass: assert property (@(posedge clk_sys) disable iff (sys_rst)
		dec.op == OP_WORD_CLAMP && !ovf_w |=> result == $past(minuend_operand - subtrahend_operand))
		else $error("unclamped word difference wrong");
	a_word_halve_val: assert property (@(posedge clk_sys) disable iff (sys_rst)
		dec.op == OP_WORD_HALVE |=> result == $past(diff_w[32:1]))
		else $error("halving word result wrong");
	a_word_halve_rnd: assert property (@(posedge clk_sys) disable iff (sys_rst)
		dec.op == OP_WORD_HALVE_RND |=> result == $past(diff_w[32:1] + diff_w[0]))
		else $error("rounding halving word result wrong");

	// ----------------------------------------
	// Checks on status flag
	// ----------------------------------------
	a_flag_sticky_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
		accumulate_status_reg[OUFLAG_BIT] && !status_wr |=> accumulate_status_reg[OUFLAG_BIT])
		else $error("overflow flag cleared without software write");
	a_word_ovf_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
		dec.op == OP_WORD_CLAMP && ovf_w |=> accumulate_status_reg[OUFLAG_BIT])
		else $error("word clamp overflow did not set flag");
	a_pair_ovf_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
		dec.op == OP_PAIR_WRAP && ovf_lo |=> accumulate_status_reg[OUFLAG_BIT] && result[15:0] == $past(diff_lo[15:0]))
		else $error("wrap lane overflow mishandled");
	a_pair_flag_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
		pair_op && (ovf_hi || ovf_lo) |=> accumulate_status_reg[OUFLAG_BIT])
		else $error("pair lane overflow did not set flag");
	a_halve_status_keep: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(dec.op == OP_PAIR_HALVE || dec.op == OP_PAIR_HALVE_RND || dec.op == OP_WORD_HALVE
		|| dec.op == OP_WORD_HALVE_RND) && !status_wr |=> accumulate_status_reg == $past(accumulate_status_reg))
		else $error("halving subtract changed status");

	// ----------------------------------------
	// Checks on answers and traps
	// ----------------------------------------
	a_valid_follows: assert property (@(posedge clk_sys) disable iff (sys_rst)
		executes |=> result_valid && !exc_reserved && !exc_dsp_disabled)
		else $error("executed op not answered cleanly");
	a_result_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!executes |=> result == $past(result))
		else $error("result changed without executed op");
	a_answer_excl: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$onehot0({result_valid, exc_reserved, exc_dsp_disabled}))
		else $error("more than one answer pulse");
	a_reserved_trap: assert property (@(posedge clk_sys) disable iff (sys_rst)
		dec.trap_reserved |=> exc_reserved && !result_valid)
		else $error("unknown instruction not trapped");
	a_disabled_trap: assert property (@(posedge clk_sys) disable iff (sys_rst)
		dec.trap_disabled |=> exc_dsp_disabled && !result_valid)
		else $error("disabled instruction not trapped");
	a_trap_no_exec: assert property (@(posedge clk_sys) disable iff (sys_rst)
		instr_valid && !dsp_enabled && !dsp_rev2_enabled |=> !result_valid)
		else $error("disabled instruction executed");
endmodule

// [fsub_pipe_model.sv]
// Pipeline model that issues subtract instructions and keeps the write-back
`timescale 1ns/10ps
module fsub_pipe_model (
	// Clock
	input wire logic clk_sys,
	// Issue side
	output logic [31:0] instr,
	output logic instr_valid,
	output logic [31:0] minuend_operand,
	output logic [31:0] subtrahend_operand,
	// Write-back side
	input wire logic [31:0] result,
	input wire logic result_valid
);
	logic [31:0] dest_reg;
	// Idle issue port at start
	initial begin
		instr = 32'h0;
		instr_valid = 1'b0;
		minuend_operand = 32'h0;
		subtrahend_operand = 32'h0;
	end
	// Destination register write-back
	always_ff @(posedge clk_sys) begin
		if (result_valid) begin
			dest_reg <= result;
		end
	end
	// One instruction for one cycle; released fields show inverted values
	task automatic issue(input logic [31:0] i, input logic [31:0] a, input logic [31:0] b);
		@(negedge clk_sys);
		instr = i;
		minuend_operand = a;
		subtrahend_operand = b;
		instr_valid = 1'b1;
		@(negedge clk_sys);
		instr_valid = 1'b0;
		instr = ~i;
		minuend_operand = ~a;
		subtrahend_operand = ~b;
	endtask
endmodule

// [tb_fractional_subtract_unit.sv]
// Self-checking testbench of the fractional subtract unit
`timescale 1ns/10ps
module tb_fractional_subtract_unit;
	import fsub_pkg::*;
	logic clk_sys, sys_rst, instr_valid, dsp_enabled, dsp_rev2_enabled, status_wr, result_valid;
	logic exc_reserved, exc_dsp_disabled;
	logic [31:0] instr, minuend_operand, subtrahend_operand, status_wdata, result, accumulate_status_reg;
	logic [31:0] exp_st;
	int errors, compares, cycles;
	// ----------------------------------------
	// Clock, design and partner
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	fractional_subtract_unit DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .instr(instr), .instr_valid(instr_valid),
		.minuend_operand(minuend_operand), .subtrahend_operand(subtrahend_operand), .dsp_enabled(dsp_enabled),
		.dsp_rev2_enabled(dsp_rev2_enabled), .status_wr(status_wr), .status_wdata(status_wdata), .result(result),
		.result_valid(result_valid), .exc_reserved(exc_reserved), .exc_dsp_disabled(exc_dsp_disabled),
		.accumulate_status_reg(accumulate_status_reg));
	fsub_pipe_model pipe (.clk_sys(clk_sys), .instr(instr), .instr_valid(instr_valid),
		.minuend_operand(minuend_operand), .subtrahend_operand(subtrahend_operand),
		.result(result), .result_valid(result_valid));
	// ----------------------------------------
	// Reporting
	// ----------------------------------------
	task automatic close_out();
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t word got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_flags(input logic [2:0] got, input logic [2:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t flags got %b want %b", $time, got, exp);
		end
	endtask
	// Watchdog on run length
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			close_out();
		end
	end
	// ----------------------------------------
	// Shared operations
	// ----------------------------------------
	task automatic wr_st(input logic [31:0] d);
		@(negedge clk_sys);
		status_wr = 1'b1;
		status_wdata = d;
		@(negedge clk_sys);
		status_wr = 1'b0;
		exp_st = d;
	endtask
	// Issue, then judge the one-cycle answer, result and status
	task automatic run(input logic v, input logic [6:0] m, input logic [31:0] a, input logic [31:0] b,
		input logic [31:0] r, input logic [2:0] ev);
		pipe.issue({21'h0, v, m, MAJOR_POOL}, a, b);
		chk_flags({result_valid, exc_reserved, exc_dsp_disabled}, ev);
		chk_word(result, r);
		chk_word(accumulate_status_reg, exp_st);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_pair();
		wr_st(32'h5);
		exp_st = 32'h100005;
		run(1'b0, MINOR_PAIR_SUB, 32'h7fff8000, 32'hffff0001, 32'h80007fff, 3'b100);
		wr_st(32'h5);
		exp_st = 32'h100005;
		run(1'b1, MINOR_PAIR_SUB, 32'h7fff8000, 32'hffff0001, 32'h7fff8000, 3'b100);
		run(1'b1, MINOR_PAIR_SUB, 32'h00030005, 32'h00010007, 32'h0002fffe, 3'b100);
	endtask
	task automatic t_word();
		wr_st(32'h5);
		run(1'b1, MINOR_WORD_SUB, 32'h5, 32'h3, 32'h2, 3'b100);
		exp_st = 32'h100005;
		run(1'b0, MINOR_WORD_SUB, 32'h80000000, 32'h1, 32'h80000000, 3'b100);
		run(1'b1, MINOR_WORD_SUB, 32'h7fffffff, 32'hffffffff, 32'h7fffffff, 3'b100);
		run(1'b1, MINOR_WORD_SUB, 32'h9, 32'h2, 32'h7, 3'b100);
	endtask
	task automatic t_halve();
		run(1'b0, MINOR_PAIR_HALVE, 32'h7fff8000, 32'h80007fff, 32'h7fff8000, 3'b100);
		run(1'b1, MINOR_PAIR_HALVE, 32'h7fff8000, 32'h80007fff, 32'h80008001, 3'b100);
		wr_st(32'h0);
		run(1'b0, MINOR_WORD_HALVE, 32'h7fffffff, 32'h80000000, 32'h7fffffff, 3'b100);
		run(1'b1, MINOR_WORD_HALVE, 32'h7fffffff, 32'h80000000, 32'h80000000, 3'b100);
	endtask
	task automatic t_exc();
		run(1'b0, 7'h00, 32'h1, 32'h2, 32'h80000000, 3'b010);
		dsp_rev2_enabled = 1'b0;
		run(1'b0, MINOR_PAIR_HALVE, 32'h1, 32'h2, 32'h80000000, 3'b001);
		dsp_rev2_enabled = 1'b1;
		dsp_enabled = 1'b0;
		run(1'b1, MINOR_WORD_SUB, 32'h80000000, 32'h1, 32'h80000000, 3'b001);
		run(1'b0, MINOR_PAIR_SUB, 32'h7fff8000, 32'hffff0001, 32'h80000000, 3'b001);
		dsp_rev2_enabled = 1'b0;
		run(1'b1, MINOR_WORD_HALVE, 32'h7fffffff, 32'h1, 32'h80000000, 3'b001);
		dsp_rev2_enabled = 1'b1;
		dsp_enabled = 1'b1;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		errors = 0;
		compares = 0;
		cycles = 0;
		exp_st = 32'h0;
		sys_rst = 1'b1;
		dsp_enabled = 1'b1;
		dsp_rev2_enabled = 1'b1;
		status_wr = 1'b0;
		status_wdata = 32'h0;
		repeat (16) @(negedge clk_sys);
		sys_rst = 1'b0;
		chk_word(accumulate_status_reg, STATUS_RESET);
		t_pair();
		t_word();
		t_halve();
		t_exc();
		close_out();
	end
endmodule
